// ===== design/wake_event_pkg.sv
// Constants for the wake event control block.
// Assumes a byte-wide register port on the controller clock.
package wake_event_pkg;
    localparam logic [7:0] wake_reg_offset = 8'h51;
    localparam logic [7:0] wake_reg_reset  = 8'h08;
    localparam int pattern_enable_bit = 0;
    localparam int magic_enable_bit   = 1;
    localparam int link_enable_bit    = 2;
    localparam int polarity_bit       = 3;
    localparam int pattern_flag_bit   = 4;
    localparam int magic_flag_bit     = 5;
    localparam int link_flag_bit      = 6;
    localparam int lan_mode_bit       = 7;
    localparam logic [7:0] writable_mask = 8'h8f;
    localparam logic [1:0] power_state_d0 = 2'h0;
    localparam int sync_stages = 3;
endpackage

// ===== design/pin_sync.sv
// Three-stage synchroniser for one pin input.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/10ps
module pin_sync (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Pin and synchronised level
    input  wire logic pin_in,
    output logic      level_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state    = state;
        next_state.s1 = pin_in;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        // A change counts only once two settled stages agree
        if (state.s2 == state.s3) begin
            next_state.level = state.s3;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level_out = state.level;
endmodule

// ===== design/wake_event_control.sv
// Wake event control: enables, sticky event flags and wake pin.
// Assumes receive filter pulses on clk_sys and a byte register port.
`timescale 1ns/10ps
module wake_event_control
    import wake_event_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    // Power management state
    input  wire logic       power_event_enable,
    input  wire logic [1:0] power_state,
    // Receive filter and PHY
    input  wire logic       pattern_packet_seen,
    input  wire logic       magic_frame_seen,
    input  wire logic       phy_link_status_input,
    // Wake outputs
    output logic            wake_pin,
    output logic            wake_event_pulse,
    output logic            lan_resume_mode
);
    import wake_event_pkg::*;

    // Whole state of the block except the link synchroniser; a single register stage holds it
    typedef struct packed {
        logic [7:0] wake_source_control_status;
        logic [7:0] rdata;
        logic [2:0] settle_count;
        logic       link_last;
        logic       link_primed;
        logic       wake_pin;
        logic       event_pulse;
        logic       lan_mode;
    } wake_state_t;

    // Edges after reset until the synchronised link level is trusted:
    // one per stage, plus one for the agreement check
    localparam logic [2:0] settle_done = 3'(sync_stages + 1);

    wake_state_t state;
    wake_state_t next_state;

    // Synchronised link status level
    logic        link_level;

    // Register decode
    logic        sel;
    logic        write_hit;
    logic        read_hit;
    logic [7:0]  written_value;

    // Named fields of the stored register value
    logic        pattern_packet_enable;
    logic        magic_frame_enable;
    logic        link_change_enable;
    logic        alert_pin_polarity;
    logic        lan_resume_mode_enable;
    logic [2:0]  enables;
    logic [2:0]  flags_now;

    // Event detection and wake decision
    logic        power_gate_open;
    logic        armed;
    logic        link_changed;
    logic [2:0]  raw_events;
    logic [2:0]  hits;
    logic [2:0]  flags_kept;
    logic [2:0]  flags_after;
    logic        asserted;

    // The link pin is asynchronous; three stages guard against metastability
    pin_sync link_sync (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .pin_in    (phy_link_status_input),
        .level_out (link_level)
    );

    // Register decode; strobes for other addresses are ignored
    assign sel       = (reg_addr == wake_reg_offset);
    assign write_hit = reg_write && sel;
    assign read_hit  = reg_read && sel;

    // Flag bits are read-only, so a write keeps the stored flags
    assign written_value = (reg_wdata & writable_mask)
                           | (state.wake_source_control_status & ~writable_mask);

    // Control fields as stored before this cycle's write
    assign pattern_packet_enable  = state.wake_source_control_status[pattern_enable_bit];
    assign magic_frame_enable     = state.wake_source_control_status[magic_enable_bit];
    assign link_change_enable     = state.wake_source_control_status[link_enable_bit];
    assign alert_pin_polarity     = state.wake_source_control_status[polarity_bit];
    assign lan_resume_mode_enable = state.wake_source_control_status[lan_mode_bit];

    // Enables and flags share one bit order: pattern, magic, link
    assign enables   = {link_change_enable, magic_frame_enable, pattern_packet_enable};
    assign flags_now = state.wake_source_control_status[link_flag_bit:pattern_flag_bit];

    // Power gate open only with power events on and outside D0
    assign power_gate_open = power_event_enable && (power_state != power_state_d0);

    // The mode bit overrides the power control settings entirely
    assign armed = power_gate_open || lan_resume_mode_enable;

    // Before the synchroniser settles the reset level is not a change
    assign link_changed = state.link_primed && (link_level != state.link_last);

    // Events gather in the same bit order as the flags
    assign raw_events = {link_changed, magic_frame_seen, pattern_packet_seen};

    // Flags record events whether or not the wake path is armed
    assign hits = raw_events & enables;

    // A read clears the flags
    assign flags_kept = read_hit ? 3'h0 : flags_now;

    // An event in the read cycle survives the clear, so none is lost
    assign flags_after = flags_kept | hits;

    // The pin holds while an enabled flag stands and the path is armed
    assign asserted = armed && ((flags_after & enables) != 3'h0);

    always_comb begin
        next_state = state;

        // Control bits take the host's write
        if (write_hit) begin
            next_state.wake_source_control_status = written_value;
        end

        // Sticky flags: cleared by a read, set by an enabled event
        next_state.wake_source_control_status[link_flag_bit:pattern_flag_bit] = flags_after;

        // Read data stands for one cycle, zero otherwise
        next_state.rdata = 8'h00;
        if (read_hit) begin
            next_state.rdata = state.wake_source_control_status;
        end

        // Link tracking waits out the synchroniser after reset
        next_state.link_last = link_level;
        if (state.settle_count != settle_done) begin
            next_state.settle_count = state.settle_count + 3'h1;
        end
        next_state.link_primed = (state.settle_count == settle_done);

        // One pulse per cycle with any enabled event while armed
        next_state.event_pulse = armed && (hits != 3'h0);

        // Pin follows the polarity that stands after this cycle's write
        next_state.wake_pin = asserted ~^ next_state.wake_source_control_status[polarity_bit];

        // Mode output mirrors the stored mode bit
        next_state.lan_mode = next_state.wake_source_control_status[lan_mode_bit];
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= '{wake_source_control_status: wake_reg_reset,
                       rdata:                      8'h00,
                       settle_count:               3'h0,
                       link_last:                  1'b0,
                       link_primed:                1'b0,
                       wake_pin:                   1'b0,
                       event_pulse:                1'b0,
                       lan_mode:                   1'b0};
        end else begin
            state <= next_state;
        end
    end

    // Every output comes straight from the state register
    assign reg_rdata        = state.rdata;
    assign wake_pin         = state.wake_pin;
    assign wake_event_pulse = state.event_pulse;
    assign lan_resume_mode  = state.lan_mode;

    // The polarity field is read through next_state above, because a
    // write that flips polarity must move the pin in the same edge.
    // alert_pin_polarity keeps the stored value for readers of this code.
    // Limitation: a link change shorter than the synchroniser's
    // agreement window is filtered out and never flagged.
    // Trade-off: flags record events even while unarmed, so the host
    // can see what happened in D0 before it arms the wake path.
endmodule

// ===== sim/wake_event_control_sva.sv
// Port checker for the wake event block; bound at the foot of this file.
`timescale 1ns/10ps
module wake_event_control_sva import wake_event_pkg::*; (
    input wire logic clk_sys, reset_n, reg_write, reg_read, power_event_enable,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic [1:0] power_state,
    input wire logic pattern_packet_seen, magic_frame_seen, wake_pin, wake_event_pulse, lan_resume_mode
);
    logic [7:0] ctl;
    wire sel = reg_addr == wake_reg_offset;
    wire arm = (power_event_enable && power_state != power_state_d0) || ctl[7];
    wire no_rx = !pattern_packet_seen && !magic_frame_seen;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) ctl <= wake_reg_reset;
        else if (reg_write && sel) ctl <= reg_wdata & writable_mask;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence magic_in; magic_frame_seen && ctl[1] && !reg_write; endsequence
    sequence rd; reg_read && sel && !reg_write && no_rx; endsequence
    a_pattern_wakes: assert property (pattern_packet_seen && ctl[0] && arm |=> wake_event_pulse) else $error("pulse");
    a_magic_wakes: assert property (magic_in ##0 arm |=> wake_event_pulse) else $error("pulse");
    a_gated_quiet: assert property (!arm |=> !wake_event_pulse) else $error("stray pulse");
    a_pin_level: assert property (magic_in ##0 arm |=> wake_pin == ctl[3]) else $error("pin level");
    a_flag_seen: assert property (magic_in ##1 !reg_read ##1 rd |=> reg_rdata[5]) else $error("flag");
    a_read_clears: assert property (no_rx ##1 rd ##1 no_rx ##1 rd |=> reg_rdata[5:4] == 2'h0) else $error("clear");
    a_ctl_readback: assert property (rd |=> {reg_rdata[7], reg_rdata[3:0]} == {ctl[7], ctl[3:0]}) else $error("read");
    a_lan_copy: assert property (!reg_write [*2] |-> lan_resume_mode == ctl[7]) else $error("mode");
endmodule
bind wake_event_control wake_event_control_sva i_wake_event_control_sva (.*);

// ===== sim/rx_side_model.sv
// Receive filter and link pin stand-in; the bench calls send between edges.
`timescale 1ns/10ps
module rx_side_model (
    input wire logic clk_sys,
    output logic pattern_packet_seen = 1'b0, magic_frame_seen = 1'b0, phy_link_status_input = 1'b0
);
    // Packets are one-cycle pulses; the link is a level that flips
    task automatic send(input int k);
        @(negedge clk_sys);
        if (k == 2) phy_link_status_input = !phy_link_status_input;
        else {magic_frame_seen, pattern_packet_seen} = (k == 1) ? 2'h2 : 2'h1;
        @(negedge clk_sys);
        {magic_frame_seen, pattern_packet_seen} = 2'h0;
    endtask
endmodule

// ===== sim/wake_event_control_tb.sv
// Bench for the wake event block; inputs change on falling edges.
`timescale 1ns/10ps
module wake_event_control_tb;
    logic clk_sys = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, power_event_enable = 1'b1;
    logic [7:0] reg_addr = 8'h51, reg_wdata = 8'h00, reg_rdata;
    logic [1:0] power_state = 2'h3;
    logic pattern_packet_seen, magic_frame_seen, phy_link_status_input, wake_pin, wake_event_pulse, lan_resume_mode;
    int err_total = 0, total_checks = 0, i;
    initial forever #25 clk_sys = !clk_sys;
    rx_side_model i_rx_side_model (.*);
    wake_event_control i_wake_event_control (.*);
    task automatic chk(input logic [7:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // A read is judged while its data stands, one cycle after the strobe
    task automatic acc(input logic w, input logic [7:0] d, input logic [7:0] a = 8'h51);
        @(negedge clk_sys);
        {reg_addr, reg_write, reg_read, reg_wdata} = {a, w, !w, d};
        @(negedge clk_sys);
        {reg_write, reg_read} = 2'h0;
        if (!w) chk(reg_rdata, d);
    endtask
    task automatic ev(input int k, input logic p);
        i_rx_side_model.send(k);
        for (i = 0; i < 8 && wake_event_pulse !== p; i++) @(negedge clk_sys);
        chk(8'(wake_event_pulse), 8'(p));
        if (i == 8) close_out();
    endtask
    task automatic t_sources;
        for (int k = 0; k < 3; k++) begin
            acc(1'b1, 8'h08 | 8'h01 << k);
            ev(k, 1'b1);
            chk(8'(wake_pin), 8'h01);
            acc(1'b0, 8'h08 | 8'h11 << k);
            acc(1'b0, 8'h08 | 8'h01 << k);
            chk(8'(wake_pin), 8'h00);
        end
        $display("sources test done");
    endtask
    task automatic t_gating;
        acc(1'b1, 8'h0d);
        ev(1, 1'b0);
        acc(1'b0, 8'h0d);
        acc(1'b1, 8'h0a);
        power_state = 2'h0;
        ev(1, 1'b0);
        acc(1'b0, 8'h2a);
        {power_state, power_event_enable} = 3'h6;
        ev(1, 1'b0);
        acc(1'b1, 8'hf2);
        chk(8'(lan_resume_mode), 8'h01);
        ev(1, 1'b1);
        chk(8'(wake_pin), 8'h00);
        acc(1'b0, 8'ha2);
        acc(1'b1, 8'hff, 8'h50);
        acc(1'b0, 8'h00, 8'h50);
        chk(8'(wake_pin), 8'h01);
        $display("gating test done");
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        acc(1'b0, 8'h08);
        t_sources();
        t_gating();
        close_out();
    end
endmodule
